//--- src/sbm_pkg.sv
// Constants, state types and helper functions for the serial receiver.
// Assumes a single 100 MHz clock and a classic Wishbone register bus.
package sbm_pkg;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_DATA   = 8'h04;
	localparam logic [7:0] ADR_CR1    = 8'h08;
	localparam logic [7:0] ADR_CR2    = 8'h0c;
	localparam logic [7:0] ADR_BAUD   = 8'h10;
	localparam logic [7:0] ADR_RXFINE = 8'h14;
	localparam logic [7:0] ADR_TXFINE = 8'h18;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int ST_FULL  = 5;
	localparam int ST_IDLE  = 4;
	localparam int ST_OVR   = 3;
	localparam int ST_NOISE = 2;
	localparam int ST_FRAME = 1;
	localparam int CR1_R9   = 7;
	localparam int CR1_M    = 4;
	localparam int CR1_WAKE = 3;
	localparam int CR2_RIE  = 5;
	localparam int CR2_IDLE_IRQ_ENABLE = 4;
	localparam int CR2_TE   = 3;
	localparam int CR2_RE   = 2;
	localparam int CR2_MUTE = 1;
	localparam int BR_CP    = 6;
	localparam int BR_TXR   = 3;
	localparam int BR_RXR   = 0;

	// ------------------------------------------------------------------
	// Sampling counts (sample index is count plus one)
	// ------------------------------------------------------------------
	localparam logic [3:0] SC_EDGE_A = 4'h2;
	localparam logic [3:0] SC_EDGE_B = 4'h4;
	localparam logic [3:0] SC_EDGE_C = 4'h6;
	localparam logic [3:0] SC_MAJ_A  = 4'h7;
	localparam logic [3:0] SC_MAJ_B  = 4'h8;
	localparam logic [3:0] SC_MAJ_C  = 4'h9;
	localparam logic [3:0] SC_LAST   = 4'hf;
	localparam logic [3:0] SC_AFTER_EDGE = 4'h1;
	localparam logic [3:0] BITS_8    = 4'h8;
	localparam logic [3:0] BITS_9    = 4'h9;
	localparam logic [7:0] IDLE_T8   = 8'h9f;
	localparam logic [7:0] IDLE_T9   = 8'haf;

	// Coarse prescale factors
	localparam logic [3:0] PR_0 = 4'h1;
	localparam logic [3:0] PR_1 = 4'h3;
	localparam logic [3:0] PR_2 = 4'h4;
	localparam logic [3:0] PR_3 = 4'hd;

	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RX_HUNT  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} sbm_rx_st_t;

	typedef struct packed {
		sbm_rx_st_t  st;
		logic [3:0]  scnt;
		logic [3:0]  bcnt;
		logic [1:0]  sm;
		logic [8:0]  sh;
		logic [2:0]  hist;
		logic [7:0]  icnt;
		logic        iarm;
		logic        nacc;
		logic        npend;
		logic        full;
		logic        ovr;
		logic        noise;
		logic        fram;
		logic        idle;
		logic [8:0]  hold;
		logic        arm_any;
		logic        arm_rd;
		logic        m9;
		logic        wake;
		logic        rx_irq_enable;
		logic        iie;
		logic        ten;
		logic        ron;
		logic        mute;
		logic [7:0]  baud;
		logic [7:0]  rxfine;
		logic [7:0]  txfine;
		logic        ack;
		logic [7:0]  dat;
		logic        irq;
	} sbm_core_t;

	typedef struct packed {
		logic [18:0] cnt;
		logic        tick;
	} sbm_baud_t;

	localparam sbm_core_t CORE_RST = '0;
	localparam sbm_baud_t BAUD_RST = '0;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic f_maj(input logic [2:0] v);
		f_maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	function automatic logic f_disagree(input logic [2:0] v);
		f_disagree = ~((&v) | ~(|v));
	endfunction

	// Clock cycles per oversample tick: PR * 2^sel * max(fine,1)
	function automatic logic [18:0] f_div(input logic [1:0] cp,
			input logic [2:0] sel, input logic [7:0] fine);
		logic [3:0]  pr;
		logic [18:0] f;
		pr = (cp == 2'b00) ? PR_0 : (cp == 2'b01) ? PR_1 :
			(cp == 2'b10) ? PR_2 : PR_3;
		f = (fine == 8'h00) ? 19'h00001 : {11'h000, fine};
		f_div = 19'({15'h0000, pr} << sel) * f;
	endfunction

endpackage

//--- src/sbm_baud.sv
// Oversample tick generator: one-cycle pulse at 16 times the baud rate.
// Assumes its settings are held still while run_i is high.
`timescale 1ns/100ps
`default_nettype none
module sbm_baud (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [1:0] cp_i,
	input  wire logic [2:0] sel_i,
	input  wire logic [7:0] fine_i,
	output logic            tick_o
);
	sbm_pkg::sbm_baud_t s_q;
	sbm_pkg::sbm_baud_t s_d;
	logic [18:0]        div;

	// ------------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------------
	always_comb begin
		div = sbm_pkg::f_div(cp_i, sel_i, fine_i); // [R16] [R18]
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run_i) begin
			s_d.cnt = 19'h00000;
		end else if (s_q.cnt >= div - 19'h00001) begin
			s_d.cnt = 19'h00000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 19'h00001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= sbm_pkg::BAUD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;

endmodule
`default_nettype wire

//--- src/sbm_rx.sv
// Asynchronous serial receiver with baud generators and mute/wake-up.
// Assumes a classic Wishbone master and a serial line synchronous to clk_i.
//
// Overview of operation
// R01: Words are 8 or 9 bits; in 9-bit mode the top bit is readable.
// R02: Bits shift in LSB first; data register reads the holding buffer.
// R03: Turning the receiver on starts the hunt for a start bit.
// R04: Completed character goes to holding buffer, sets full, may interrupt.
// R05: Full clears on status access then data read, before next character.
// R06: Character while full sets overrun, keeps buffer, may interrupt.
// R07: Overrun clears on status access then data read.
// R08: Data bits compare samples 8, 9, 10; disagreement flags noise.
// R09: Noise appears with full, data still transferred, no own interrupt.
// R10: Noise clears on status read then data read.
// R11: False start drops frame; noise held for the next good frame.
// R12: A break is handled as a framing error.
// R13: Missing stop bit sets framing with full, data transferred.
// R14: Framing clears on status read then data read.
// R15: Idle frame sets idle flag and interrupts when idle enable set.
// R16: Rate is clock over 16, coarse prescale and power-of-two select.
// R17: Software keeps baud settings still while either direction is on.
// R18: Nonzero fine prescale divides further by 1 to 255; zero bypasses.
// R19: While muted no receive status bit sets and no interrupt requests.
// R20: Idle wake method: idle frame clears mute, idle flag stays clear.
// R21: Address wake method: word with top bit 1 unmutes and sets full.
// R22: Software avoids writing control two while muted.
// R23: Sixteen samples per bit; value is majority of samples 8, 9, 10.
// R24: Start edge needs three ones before; ones at 3, 5, 7 flag noise.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module sbm_rx (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        serial_rx_input_i,
	input  wire logic        irq_mask_i,
	output logic             irq_o,
	output logic             tx_tick_o
);
	sbm_pkg::sbm_core_t s_q;
	sbm_pkg::sbm_core_t s_d;
	logic       rx_tick;
	logic       hit;
	logic       frame_done;
	logic       stop_ok;
	logic       idle_ev;
	logic       wake_addr;
	logic       accept;
	logic [2:0] v;
	logic [3:0] nbits;
	logic [7:0] idle_lim;
	logic [8:0] word;
	logic [7:0] rv;

	// ------------------------------------------------------------------
	// Baud generators
	// ------------------------------------------------------------------
	sbm_baud u_rx_baud (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (s_q.ron),
		.cp_i   (s_q.baud[sbm_pkg::BR_CP +: 2]),
		.sel_i  (s_q.baud[sbm_pkg::BR_RXR +: 3]),
		.fine_i (s_q.rxfine),
		.tick_o (rx_tick)
	);

	sbm_baud u_tx_baud (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (s_q.ten),
		.cp_i   (s_q.baud[sbm_pkg::BR_CP +: 2]),
		.sel_i  (s_q.baud[sbm_pkg::BR_TXR +: 3]),
		.fine_i (s_q.txfine),
		.tick_o (tx_tick_o)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		frame_done = 1'b0;
		stop_ok = 1'b0;
		idle_ev = 1'b0;
		v = {s_q.sm, serial_rx_input_i};
		nbits = s_q.m9 ? sbm_pkg::BITS_9 : sbm_pkg::BITS_8; // [R01]
		idle_lim = s_q.m9 ? sbm_pkg::IDLE_T9 : sbm_pkg::IDLE_T8;
		word = s_q.m9 ? s_q.sh : {1'b0, s_q.sh[8:1]};
		wake_addr = s_q.mute & s_q.wake & s_q.sh[8];
		accept = ~s_q.mute | wake_addr;
		hit = wb_cyc_i & wb_stb_i & ~s_q.ack;
		s_d.ack = hit;

		// Receive sequencer
		if (!s_q.ron) begin
			s_d.st = sbm_pkg::RX_HUNT;
			s_d.hist = 3'b000;
			s_d.icnt = 8'h00;
			s_d.iarm = 1'b1;
			s_d.nacc = 1'b0;
		end else if (rx_tick) begin
			if (s_q.st != sbm_pkg::RX_HUNT) begin
				s_d.scnt = s_q.scnt + 4'h1; // [R23]
			end
			if (s_q.scnt == sbm_pkg::SC_MAJ_A ||
					s_q.scnt == sbm_pkg::SC_MAJ_B) begin
				s_d.sm = {s_q.sm[0], serial_rx_input_i};
			end
			unique case (s_q.st)
				sbm_pkg::RX_HUNT: begin
					if (serial_rx_input_i) begin
						s_d.icnt = s_q.icnt + 8'h01;
					end else begin
						s_d.icnt = 8'h00;
					end
					if (s_q.iarm && serial_rx_input_i &&
							s_q.icnt == idle_lim) begin
						idle_ev = 1'b1;
						s_d.iarm = 1'b0;
					end
					s_d.hist = {s_q.hist[1:0], serial_rx_input_i};
					if (!serial_rx_input_i && s_q.hist == 3'b111) begin
						s_d.st = sbm_pkg::RX_START; // [R03] [R24]
						s_d.scnt = sbm_pkg::SC_AFTER_EDGE;
						s_d.nacc = s_q.npend; // [R11]
						s_d.npend = 1'b0;
					end
				end
				sbm_pkg::RX_START: begin
					if (serial_rx_input_i &&
							(s_q.scnt == sbm_pkg::SC_EDGE_A ||
							s_q.scnt == sbm_pkg::SC_EDGE_B ||
							s_q.scnt == sbm_pkg::SC_EDGE_C)) begin
						s_d.nacc = 1'b1; // [R24]
					end
					if (s_q.scnt == sbm_pkg::SC_MAJ_C) begin
						if (sbm_pkg::f_maj(v)) begin
							s_d.st = sbm_pkg::RX_HUNT; // [R11]
							s_d.hist = 3'b000;
							s_d.npend = 1'b1;
						end else if (sbm_pkg::f_disagree(v)) begin
							s_d.nacc = 1'b1;
						end
					end
					if (s_q.scnt == sbm_pkg::SC_LAST) begin
						s_d.st = sbm_pkg::RX_DATA;
						s_d.bcnt = 4'h0;
					end
				end
				sbm_pkg::RX_DATA: begin
					if (s_q.scnt == sbm_pkg::SC_MAJ_C) begin
						s_d.sh = {sbm_pkg::f_maj(v), s_q.sh[8:1]}; // [R02]
						if (sbm_pkg::f_disagree(v)) begin
							s_d.nacc = 1'b1; // [R08]
						end
					end
					if (s_q.scnt == sbm_pkg::SC_LAST) begin
						s_d.bcnt = s_q.bcnt + 4'h1;
						if (s_q.bcnt == nbits - 4'h1) begin
							s_d.st = sbm_pkg::RX_STOP;
						end
					end
				end
				sbm_pkg::RX_STOP: begin
					if (s_q.scnt == sbm_pkg::SC_MAJ_C) begin
						frame_done = 1'b1;
						stop_ok = sbm_pkg::f_maj(v); // [R12] [R13]
						s_d.st = sbm_pkg::RX_HUNT;
						s_d.hist = 3'b000;
						s_d.icnt = 8'h00;
						s_d.iarm = 1'b1;
					end
				end
			endcase
		end

		// Register access
		rv = 8'h00;
		if (hit) begin
			unique case (wb_adr_i)
				sbm_pkg::ADR_STATUS: begin
					rv[sbm_pkg::ST_FULL] = s_q.full;
					rv[sbm_pkg::ST_IDLE] = s_q.idle;
					rv[sbm_pkg::ST_OVR] = s_q.ovr;
					rv[sbm_pkg::ST_NOISE] = s_q.noise;
					rv[sbm_pkg::ST_FRAME] = s_q.fram;
					s_d.arm_any = 1'b1;
					s_d.arm_rd = ~wb_we_i | s_q.arm_rd;
				end
				sbm_pkg::ADR_DATA: begin
					rv = s_q.hold[7:0]; // [R02]
					if (!wb_we_i) begin
						if (s_q.arm_any) begin
							s_d.full = 1'b0; // [R05]
							s_d.ovr = 1'b0; // [R07]
							s_d.idle = 1'b0;
						end
						if (s_q.arm_rd) begin
							s_d.noise = 1'b0; // [R10]
							s_d.fram = 1'b0; // [R14]
						end
						s_d.arm_any = 1'b0;
						s_d.arm_rd = 1'b0;
					end
				end
				sbm_pkg::ADR_CR1: begin
					rv[sbm_pkg::CR1_R9] = s_q.hold[8]; // [R01]
					rv[sbm_pkg::CR1_M] = s_q.m9;
					rv[sbm_pkg::CR1_WAKE] = s_q.wake;
					if (wb_we_i && wb_sel_i[0]) begin
						s_d.m9 = wb_dat_i[sbm_pkg::CR1_M];
						s_d.wake = wb_dat_i[sbm_pkg::CR1_WAKE];
					end
				end
				sbm_pkg::ADR_CR2: begin
					rv[sbm_pkg::CR2_RIE] = s_q.rx_irq_enable;
					rv[sbm_pkg::CR2_IDLE_IRQ_ENABLE] = s_q.iie;
					rv[sbm_pkg::CR2_TE] = s_q.ten;
					rv[sbm_pkg::CR2_RE] = s_q.ron;
					rv[sbm_pkg::CR2_MUTE] = s_q.mute;
				end
				sbm_pkg::ADR_BAUD: begin
					rv = s_q.baud;
					if (wb_we_i && wb_sel_i[0]) begin
						s_d.baud = wb_dat_i[7:0]; // [R16]
					end
				end
				sbm_pkg::ADR_RXFINE: begin
					rv = s_q.rxfine;
					if (wb_we_i && wb_sel_i[0]) begin
						s_d.rxfine = wb_dat_i[7:0]; // [R18]
					end
				end
				sbm_pkg::ADR_TXFINE: begin
					rv = s_q.txfine;
					if (wb_we_i && wb_sel_i[0]) begin
						s_d.txfine = wb_dat_i[7:0]; // [R18]
					end
				end
				default: begin
					rv = 8'h00;
				end
			endcase
		end
		s_d.dat = hit ? rv : 8'h00;

		// Hardware sets follow the clears so a coincident event wins
		if (frame_done) begin
			if (accept) begin
				if (s_q.full) begin
					s_d.ovr = 1'b1; // [R06]
				end else begin
					s_d.hold = word; // [R04]
					s_d.full = 1'b1; // [R21]
					s_d.noise = s_q.nacc; // [R09]
					s_d.fram = ~stop_ok; // [R13]
				end
			end
			if (wake_addr) begin
				s_d.mute = 1'b0; // [R21]
			end
			s_d.nacc = 1'b0;
		end
		if (idle_ev) begin
			if (!s_q.mute) begin
				s_d.idle = 1'b1; // [R15]
			end else if (!s_q.wake) begin
				s_d.mute = 1'b0; // [R20]
			end
		end

		// Control two is written last: a software write overrides wake-up
		if (hit && wb_we_i && wb_sel_i[0] && wb_adr_i == sbm_pkg::ADR_CR2) begin
			s_d.rx_irq_enable = wb_dat_i[sbm_pkg::CR2_RIE];
			s_d.iie = wb_dat_i[sbm_pkg::CR2_IDLE_IRQ_ENABLE];
			s_d.ten = wb_dat_i[sbm_pkg::CR2_TE];
			s_d.ron = wb_dat_i[sbm_pkg::CR2_RE]; // [R03]
			s_d.mute = wb_dat_i[sbm_pkg::CR2_MUTE]; // [R22]
		end

		// Interrupt request, suppressed while muted
		s_d.irq = ~irq_mask_i & ~s_q.mute &
			((s_q.rx_irq_enable & (s_q.full | s_q.ovr)) | (s_q.iie & s_q.idle)); // [R19]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= sbm_pkg::CORE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = {24'h000000, s_q.dat};
	assign wb_ack_o = s_q.ack;
	assign irq_o = s_q.irq;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held"); // [R05]

	property p_full_set;
		frame_done && !s_q.mute && !s_q.full |=>
			s_q.full && s_q.hold == $past(word);
	endproperty
	a_full_set: assert property (p_full_set) else $error("no transfer"); // [R04]

	property p_overrun;
		frame_done && !s_q.mute && s_q.full |=>
			s_q.ovr && $stable(s_q.hold);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun wrong"); // [R06]

	property p_clear;
		hit && !wb_we_i && wb_adr_i == sbm_pkg::ADR_DATA && s_q.arm_rd &&
			!frame_done |=> !s_q.full && !s_q.ovr && !s_q.noise && !s_q.fram;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared"); // [R10]

	property p_mute_quiet;
		s_q.mute && !wake_addr && !(hit && wb_we_i) |=>
			!$rose(s_q.full) && !$rose(s_q.idle);
	endproperty
	a_mute_quiet: assert property (p_mute_quiet) else $error("muted set"); // [R19]

	property p_mute_irq;
		s_q.mute |=> !irq_o;
	endproperty
	a_mute_irq: assert property (p_mute_irq) else $error("muted irq"); // [R19]

	property p_irq;
		s_q.full && s_q.rx_irq_enable && !s_q.mute && !irq_mask_i |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("missing irq"); // [R04]

	property p_frame;
		frame_done && !stop_ok && !s_q.mute && !s_q.full |=> s_q.fram;
	endproperty
	a_frame: assert property (p_frame) else $error("framing missed"); // [R13]

	property p_idle_wake;
		idle_ev && s_q.mute && !s_q.wake && !(hit && wb_we_i) |=>
			!s_q.mute && !$rose(s_q.idle);
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake"); // [R20]

	property p_off_hunt;
		!s_q.ron |=> s_q.st == sbm_pkg::RX_HUNT;
	endproperty
	a_off_hunt: assert property (p_off_hunt) else $error("not hunting"); // [R03]

endmodule
`default_nettype wire

//--- sim/sbm_line_model.sv
// Far-side sender: drives asynchronous frames onto the receiver's line.
// Assumes calls come from a process synchronous to clk_i; line idles high.
`timescale 1ns/100ps
`default_nettype none
module sbm_line_model (
	input  wire logic clk_i,
	output logic      line_o
);
	initial line_o = 1'b1;

	// --------------------------------------------------------------
	// Frame: start, nb data bits, stop; spb clocks per sample
	// --------------------------------------------------------------
	task automatic send(input logic [8:0] w, input int nb, input int spb,
			input int nz, input logic stp, input logic fls);
		logic v;
		for (int b = 0; b < nb + 2; b++) begin
			v = (b == 0) ? 1'b0 : (b > nb) ? stp : w[b - 1];
			for (int s = 0; s < 16 * spb; s++) begin
				@(posedge clk_i);
				if (fls && b == 0 && s >= 6 * spb)
					line_o <= 1'b1;
				else if (nz != 0 && b == nz && s / spb == 9)
					line_o <= ~v;
				else
					line_o <= v;
			end
			if (fls)
				break;
		end
		@(posedge clk_i);
		line_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- sim/sbm_rx_tb_top.sv
// Self-checking bench: registers over Wishbone, frames from the line model.
// Assumes sbm_pkg, sbm_rx and sbm_line_model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module sbm_rx_tb_top;
	typedef struct packed {
		logic [8:0] w;
		logic       m9;
		logic [3:0] nz;
		logic       stp;
		logic [3:0] spb;
		logic [7:0] est;
	} sbm_row_t;

	localparam logic [31:0] MSK = 32'hffffffef;

	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [7:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        line;
	logic        irq_mask;
	logic        irq;
	logic        tx_tick;
	int          fail_count;
	int          check_count;
	int          cyc_cnt;
	int          n;
	sbm_row_t    rows [6] = '{
		'{9'h0a5, 1'b0, 4'h0, 1'b1, 4'h1, 8'h20},
		'{9'h0c3, 1'b0, 4'h0, 1'b1, 4'h3, 8'h20},
		'{9'h03c, 1'b0, 4'h3, 1'b1, 4'h1, 8'h24},
		'{9'h000, 1'b0, 4'h0, 1'b0, 4'h1, 8'h22},
		'{9'h15a, 1'b1, 4'h0, 1'b1, 4'h1, 8'h20},
		'{9'h0ff, 1'b1, 4'h9, 1'b1, 4'h1, 8'h24}};
	// Tick period, baud select, tx fine prescale
	logic [31:0] brow [5] = '{32'h000c5000, 32'h000dc000, 32'h00288805,
		32'h00803800, 32'h00ff00ff};

	sbm_rx u_sbm_rx (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.wb_cyc_i          (wb_cyc),
		.wb_stb_i          (wb_stb),
		.wb_we_i           (wb_we),
		.wb_adr_i          (wb_adr),
		.wb_sel_i          (4'hf),
		.wb_dat_i          (wb_wdat),
		.wb_dat_o          (wb_rdat),
		.wb_ack_o          (wb_ack),
		.serial_rx_input_i (line),
		.irq_mask_i        (irq_mask),
		.irq_o             (irq),
		.tx_tick_o         (tx_tick)
	);

	sbm_line_model u_sbm_line_model (
		.clk_i  (clk_i),
		.line_o (line)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// --------------------------------------------------------------
	// Checking and bus tasks
	// --------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
			input logic [7:0] d, output logic [31:0] r);
		@(posedge clk_i);
		chk(wb_ack, 1'b0);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= w;
		wb_adr  <= a;
		wb_wdat <= {24'h000000, d};
		@(posedge clk_i);
		while (wb_ack !== 1'b1)
			@(posedge clk_i);
		r = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(r & m, e);
	endtask

	task automatic sd(input logic [7:0] s, input logic [7:0] d);
		rdc(sbm_pkg::ADR_STATUS, {24'h000000, s}, MSK);
		rdc(sbm_pkg::ADR_DATA, {24'h000000, d}, '1);
	endtask

	task automatic sn(input logic [8:0] w, input int nz, input logic fls);
		u_sbm_line_model.send(w, 8, 1, nz, 1'b1, fls);
	endtask

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 40000) begin
			fail_count++;
			test_done();
		end
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 32'h00000000;
		irq_mask = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(sbm_pkg::ADR_CR2, 32'h0, '1);
		rdc(8'h20, 32'h0, '1);
		wr(sbm_pkg::ADR_CR2, 8'h20);
		sn(9'h055, 0, 1'b0);
		chk(irq, 1'b0);
		rdc(sbm_pkg::ADR_STATUS, 32'h0, MSK);
		foreach (rows[i]) begin
			wr(sbm_pkg::ADR_CR2, 8'h00);
			wr(sbm_pkg::ADR_RXFINE, rows[i].spb == 1 ? 8'h00 :
				{4'h0, rows[i].spb});
			wr(sbm_pkg::ADR_CR1, {3'h0, rows[i].m9, 4'h0});
			wr(sbm_pkg::ADR_CR2, 8'h24);
			repeat (64) @(posedge clk_i);
			u_sbm_line_model.send(rows[i].w, rows[i].m9 ? 9 : 8,
				rows[i].spb, rows[i].nz, rows[i].stp, 1'b0);
			chk(irq, 1'b1);
			if (rows[i].m9)
				rdc(sbm_pkg::ADR_CR1, {rows[i].w[8], 7'h10}, '1);
			sd(rows[i].est, rows[i].w[7:0]);
			repeat (2) @(posedge clk_i);
			chk(irq, 1'b0);
		end
		wr(sbm_pkg::ADR_CR1, 8'h00);
		// Overrun with the interrupt masked, then unmasked
		irq_mask <= 1'b1;
		sn(9'h011, 0, 1'b0);
		sn(9'h022, 0, 1'b0);
		chk(irq, 1'b0);
		irq_mask <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(irq, 1'b1);
		sd(8'h28, 8'h11);
		sd(8'h00, 8'h11);
		// Data read alone, then status write, leave noise behind
		sn(9'h096, 2, 1'b0);
		rdc(sbm_pkg::ADR_DATA, 32'h96, '1);
		chk(irq, 1'b1);
		wr(sbm_pkg::ADR_STATUS, 8'hff);
		rdc(sbm_pkg::ADR_DATA, 32'h96, '1);
		rdc(sbm_pkg::ADR_STATUS, 32'h04, MSK);
		rdc(sbm_pkg::ADR_DATA, 32'h96, '1);
		rdc(sbm_pkg::ADR_STATUS, 32'h00, MSK);
		// False start, noise shows with the next good frame
		sn(9'h000, 0, 1'b1);
		repeat (64) @(posedge clk_i);
		chk(irq, 1'b0);
		sn(9'h05a, 0, 1'b0);
		sd(8'h24, 8'h5a);
		// Idle line flag and its interrupt
		wr(sbm_pkg::ADR_CR2, 8'h14);
		repeat (200) @(posedge clk_i);
		chk(irq, 1'b1);
		rdc(sbm_pkg::ADR_STATUS, 32'h10, '1);
		rdc(sbm_pkg::ADR_DATA, 32'h5a, '1);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b0);
		// Mute, woken by idle line
		wr(sbm_pkg::ADR_CR2, 8'h36);
		sn(9'h033, 0, 1'b0);
		chk(irq, 1'b0);
		rdc(sbm_pkg::ADR_STATUS, 32'h0, '1);
		repeat (200) @(posedge clk_i);
		rdc(sbm_pkg::ADR_CR2, 32'h34, '1);
		rdc(sbm_pkg::ADR_STATUS, 32'h0, '1);
		// Mute, woken by address mark
		wr(sbm_pkg::ADR_CR1, 8'h08);
		wr(sbm_pkg::ADR_CR2, 8'h26);
		sn(9'h07f, 0, 1'b0);
		chk(irq, 1'b0);
		sn(9'h080, 0, 1'b0);
		chk(irq, 1'b1);
		rdc(sbm_pkg::ADR_CR2, 32'h24, '1);
		sd(8'h20, 8'h80);
		// Transmit tick period per divider setting
		foreach (brow[i]) begin
			wr(sbm_pkg::ADR_CR2, 8'h00);
			wr(sbm_pkg::ADR_BAUD, brow[i][15:8]);
			wr(sbm_pkg::ADR_TXFINE, brow[i][7:0]);
			wr(sbm_pkg::ADR_CR2, 8'h08);
			for (int k = 0; k < 600 && tx_tick !== 1'b1; k++)
				@(posedge clk_i);
			@(posedge clk_i);
			n = 1;
			while (n < 600 && tx_tick !== 1'b1) begin
				@(posedge clk_i);
				n++;
			end
			chk(n, {16'h0000, brow[i][31:16]});
		end
		// Reset in mid-run clears control two, tx fine prescale and the tx tick
		wr(sbm_pkg::ADR_CR2, 8'h36);
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(tx_tick, 1'b0);
		rdc(sbm_pkg::ADR_CR2, 32'h0, '1);
		rdc(sbm_pkg::ADR_TXFINE, 32'h0, '1);
		test_done();
	end
endmodule
`default_nettype wire
